// *** pcr_pkg.sv ***
// Constants for the copper port management registers.
// Assumes a single 50 MHz system clock.
package pcr_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int RST_HOLD_NS = 102_000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PRE_LEN = 32;
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STATE = 5'h01;
  localparam logic [4:0] IDX_IDH = 5'h02;
  localparam logic [4:0] IDX_IDL = 5'h03;
  localparam logic [4:0] IDX_OFFER = 5'h04;
  localparam logic [4:0] IDX_PARTNER = 5'h05;
  localparam logic [4:0] IDX_EXPAN = 5'h06;
  localparam logic [4:0] IDX_MODE = 5'h11;
  localparam logic [4:0] IDX_SPECIAL = 5'h12;
  localparam logic [4:0] IDX_INDIC = 5'h1b;
  localparam logic [4:0] IDX_FLAGS = 5'h1d;
  localparam logic [4:0] IDX_ENABLES = 5'h1e;
  localparam logic [4:0] IDX_SCTRL = 5'h1f;
  localparam int B_RST = 15;
  localparam int B_LOOP = 14;
  localparam int B_SPD = 13;
  localparam int B_AN = 12;
  localparam int B_PD = 11;
  localparam int B_RSV = 10;
  localparam int B_RAN = 9;
  localparam int B_DUP = 8;
  localparam int B_COL = 7;
  localparam logic [15:0] CTRL_WMASK = 16'h7980;
  localparam logic [15:0] STATE_CAP = 16'h7809;
  localparam int ST_AN_DONE = 5;
  localparam int ST_LINK = 2;
  localparam logic [15:0] GEN_RST = 16'h0000;
  localparam logic [15:0] NO_DEV_DATA = 16'hffff;
  localparam logic [1:0] OP_RD = 2'b10;
  localparam logic [1:0] OP_WR = 2'b01;
  localparam int GEN_SLOTS = 6;
endpackage

// *** pcr_mgmt_if.sv ***
// Request channel from the serial management frame decoder to the register set.
// Request is a one-cycle pulse; hit and read data answer in the same cycle.
interface pcr_mgmt_if;
  logic req;
  logic wr;
  logic [4:0] phy;
  logic [4:0] idx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic hit;
  modport frame (output req, wr, phy, idx, wdata, input rdata, hit);
  modport regs (input req, wr, phy, idx, wdata, output rdata, hit);
endinterface

// *** pcr_mdio_slave.sv ***
// Clause 22 management frame decoder on the MII management pins.
// Assumes mdc and mdio_i are synchronous to clk_sys and mdc is much slower.
module pcr_mdio_slave
  import pcr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic enable,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  pcr_mgmt_if.frame bus
);
  typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_TA1, S_TA2, S_DATA} pcr_mdio_st_t;
  pcr_mdio_st_t state_reg;
  logic mdc_reg;
  logic [5:0] cnt_reg;
  logic [10:0] hdr_reg;
  logic [15:0] sh_reg;
  logic rd_reg;
  logic ok_reg;
  logic req_reg;
  logic wr_reg;
  logic [4:0] phy_reg;
  logic [4:0] idx_reg;
  logic rise;
  logic [11:0] full;

  assign rise = mdc & ~mdc_reg;
  assign full = {hdr_reg, mdio_i};
  assign bus.req = req_reg;
  assign bus.wr = wr_reg;
  assign bus.phy = phy_reg;
  assign bus.idx = idx_reg;
  assign bus.wdata = sh_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) mdc_reg <= 1'b0;
    else mdc_reg <= mdc;
  end

  // Frame sequence, 16-bit data per frame
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_PRE;
      cnt_reg <= 6'h00;
      hdr_reg <= 11'h000;
      sh_reg <= 16'h0000;
      rd_reg <= 1'b0;
      ok_reg <= 1'b0;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      phy_reg <= 5'h00;
      idx_reg <= 5'h00;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (!enable) begin
      state_reg <= S_PRE;
      cnt_reg <= 6'h00;
      req_reg <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      req_reg <= 1'b0;
      if (req_reg && !wr_reg) begin
        sh_reg <= bus.rdata;
        ok_reg <= bus.hit;
      end
      if (rise) begin
        case (state_reg)
          S_PRE: begin
            if (mdio_i) begin
              if (cnt_reg < 6'(PRE_LEN)) cnt_reg <= cnt_reg + 6'h01;
            end else begin
              if (cnt_reg == 6'(PRE_LEN)) state_reg <= S_ST;
              cnt_reg <= 6'h00;
            end
          end
          S_ST: begin
            state_reg <= mdio_i ? S_HDR : S_PRE;
          end
          S_HDR: begin
            hdr_reg <= full[10:0];
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'd11) begin
              cnt_reg <= 6'h00;
              phy_reg <= full[9:5];
              idx_reg <= full[4:0];
              rd_reg <= (full[11:10] == OP_RD);
              req_reg <= (full[11:10] == OP_RD);
              wr_reg <= 1'b0;
              ok_reg <= 1'b0;
              state_reg <= (full[11:10] == OP_RD || full[11:10] == OP_WR) ? S_TA1 : S_PRE;
            end
          end
          S_TA1: begin
            mdio_o <= 1'b0;
            mdio_oe <= rd_reg & ok_reg;
            state_reg <= S_TA2;
          end
          S_TA2: begin
            mdio_o <= sh_reg[15];
            sh_reg <= {sh_reg[14:0], 1'b0};
            state_reg <= S_DATA;
          end
          default: begin
            cnt_reg <= cnt_reg + 6'h01;
            if (rd_reg) begin
              mdio_o <= sh_reg[15];
              sh_reg <= {sh_reg[14:0], 1'b0};
            end else begin
              sh_reg <= {sh_reg[14:0], mdio_i};
            end
            if (cnt_reg == 6'd15) begin
              cnt_reg <= 6'h00;
              mdio_oe <= 1'b0;
              req_reg <= ~rd_reg;
              wr_reg <= ~rd_reg;
              state_reg <= S_PRE;
            end
          end
        endcase
      end
    end
  end
endmodule

// *** pcr_port_regs.sv ***
// Management register set of the two copper port transceivers.
// Assumes straps are stable at reset release and all inputs are synchronous to clk_sys.
module pcr_port_regs
  import pcr_pkg::*;
#(
  parameter logic [4:0] PORT1_ADDR = 5'h01,
  parameter logic [4:0] PORT2_ADDR = 5'h02,
  // Identification values are arbitrary
  parameter logic [15:0] IDENT_HIGH = 16'h0000,
  parameter logic [15:0] IDENT_LOW = 16'h0000,
  parameter int unsigned RST_HOLD = pcr_pkg::RST_HOLD_CYC
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ext_mgmt_mode,
  input wire logic [1:0] strap_autoneg,
  input wire logic [1:0] strap_speed,
  input wire logic [1:0] strap_duplex,
  input wire logic loader_wr,
  input wire logic loader_port,
  input wire logic [15:0] loader_data,
  input wire logic ind_cmd_wr,
  input wire logic ind_cmd_read,
  input wire logic [4:0] ind_cmd_addr,
  input wire logic [4:0] ind_cmd_index,
  input wire logic ind_val_wr,
  input wire logic [15:0] ind_val_wdata,
  output logic [15:0] ind_val_rdata,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [1:0] neg_done,
  input wire logic [1:0] neg_speed_100,
  input wire logic [1:0] neg_full_duplex,
  input wire logic [1:0] link_up,
  input wire logic [1:0][15:0] partner_offer,
  input wire logic [1:0][15:0] event_set,
  output logic [1:0] port_speed_100,
  output logic [1:0] port_full_duplex,
  output logic [1:0] fabric_loop_enable,
  output logic [1:0] transceiver_power_down,
  output logic [1:0] negotiation_enable,
  output logic [1:0] negotiation_restart,
  output logic [1:0] collision_test,
  output logic [1:0] transceiver_reset_hold
);
  localparam int CW = $clog2(RST_HOLD + 1);

  pcr_mgmt_if mif ();

  logic strap_done_reg;
  logic [1:0][15:0] ctrl_reg;
  logic [1:0][CW-1:0] rst_cnt_reg;
  logic [1:0][GEN_SLOTS-1:0][15:0] gen_reg;
  logic [1:0][15:0] flags_reg;
  logic [1:0] restart_reg;
  logic [15:0] value_reg;
  logic acc_rd;
  logic acc_wr;
  logic [4:0] acc_addr;
  logic [4:0] acc_idx;
  logic [15:0] acc_wdata;
  logic acc_hit;
  logic acc_port;
  logic [15:0] acc_rdata;
  logic [1:0] rst_busy;

  // Slot of a plain read/write register, GEN_SLOTS when none
  function automatic logic [2:0] gen_slot(input logic [4:0] idx);
    logic [2:0] s;
    s = 3'(GEN_SLOTS);
    if (idx == IDX_OFFER) s = 3'h0;
    else if (idx == IDX_MODE) s = 3'h1;
    else if (idx == IDX_SPECIAL) s = 3'h2;
    else if (idx == IDX_INDIC) s = 3'h3;
    else if (idx == IDX_ENABLES) s = 3'h4;
    else if (idx == IDX_SCTRL) s = 3'h5;
    return s;
  endfunction

  // Control register value taken from the straps
  function automatic logic [15:0] ctrl_dflt(input logic an, input logic spd, input logic dup);
    logic [15:0] v;
    v = 16'h0000;
    v[B_SPD] = an | spd;
    v[B_AN] = an;
    v[B_DUP] = ~an & dup;
    return v;
  endfunction

  pcr_mdio_slave u_mdio (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .enable(ext_mgmt_mode),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .bus(mif.frame)
  );

  always_comb begin
    if (ext_mgmt_mode) begin
      acc_rd = mif.req & ~mif.wr;
      acc_wr = mif.req & mif.wr;
      acc_addr = mif.phy;
      acc_idx = mif.idx;
      acc_wdata = mif.wdata;
    end else begin
      acc_rd = ind_cmd_wr & ind_cmd_read;
      acc_wr = ind_cmd_wr & ~ind_cmd_read;
      acc_addr = ind_cmd_addr;
      acc_idx = ind_cmd_index;
      acc_wdata = value_reg;
    end
  end

  assign acc_hit = (acc_addr == PORT1_ADDR) || (acc_addr == PORT2_ADDR);
  assign acc_port = (acc_addr == PORT2_ADDR);

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      rst_busy[p] = (rst_cnt_reg[p] != '0);
    end
  end

  always_comb begin
    logic [15:0] c;
    logic [15:0] st;
    logic [2:0] s;
    c = ctrl_reg[acc_port];
    st = STATE_CAP;
    s = gen_slot(acc_idx);
    // Busy reset reads one, reserved reads zero
    c[B_RST] = rst_busy[acc_port];
    c[B_RSV] = 1'b0;
    c[B_RAN] = 1'b0;
    st[ST_AN_DONE] = neg_done[acc_port] & ctrl_reg[acc_port][B_AN] & ~ctrl_reg[acc_port][B_PD];
    st[ST_LINK] = link_up[acc_port] & ~ctrl_reg[acc_port][B_PD];
    acc_rdata = 16'h0000;
    if (!acc_hit) acc_rdata = NO_DEV_DATA;
    else if (acc_idx == IDX_CTRL) acc_rdata = c;
    else if (acc_idx == IDX_STATE) acc_rdata = st;
    else if (acc_idx == IDX_IDH) acc_rdata = IDENT_HIGH;
    else if (acc_idx == IDX_IDL) acc_rdata = IDENT_LOW;
    else if (acc_idx == IDX_PARTNER) acc_rdata = partner_offer[acc_port];
    else if (acc_idx == IDX_EXPAN) acc_rdata = 16'h0000;
    else if (acc_idx == IDX_FLAGS) acc_rdata = flags_reg[acc_port];
    else if (s != 3'(GEN_SLOTS)) acc_rdata = gen_reg[acc_port][s];
  end

  assign mif.rdata = acc_rdata;
  assign mif.hit = acc_hit;

  // Strap capture on the first edge after reset release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) strap_done_reg <= 1'b0;
    else strap_done_reg <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) value_reg <= 16'h0000;
    else if (!ext_mgmt_mode && acc_rd) value_reg <= acc_rdata;
    else if (!ext_mgmt_mode && ind_val_wr) value_reg <= ind_val_wdata;
  end

  assign ind_val_rdata = value_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_cnt_reg <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (rst_busy[p]) begin
          rst_cnt_reg[p] <= rst_cnt_reg[p] - CW'(1);
        end else if (loader_wr && loader_port == p[0]) begin
          // Loader wins over a bus write in the same cycle
          if (loader_data[B_RST]) rst_cnt_reg[p] <= CW'(RST_HOLD);
        end else if (acc_wr && acc_hit && acc_port == p[0] && acc_idx == IDX_CTRL && acc_wdata[B_RST]) begin
          rst_cnt_reg[p] <= CW'(RST_HOLD);
        end
      end
    end
  end

  // Control register per port
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (!strap_done_reg || rst_busy[p]) begin
          // Strap defaults, also under soft reset
          ctrl_reg[p] <= ctrl_dflt(strap_autoneg[p], strap_speed[p], strap_duplex[p]);
        end else if (loader_wr && loader_port == p[0]) begin
          ctrl_reg[p] <= loader_data & CTRL_WMASK;
        end else if (acc_wr && acc_hit && acc_port == p[0] && acc_idx == IDX_CTRL) begin
          // Reserved and self-clearing bits not stored
          ctrl_reg[p] <= acc_wdata & CTRL_WMASK;
        end
      end
    end
  end

  // Negotiation restart pulse
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      restart_reg <= 2'b00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        restart_reg[p] <= strap_done_reg && !rst_busy[p] && acc_wr && acc_hit && acc_port == p[0]
          && acc_idx == IDX_CTRL && acc_wdata[B_RAN];
      end
    end
  end

  // Plain registers return to defaults under soft reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gen_reg <= {2 * GEN_SLOTS{GEN_RST}};
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (rst_busy[p]) begin
          gen_reg[p] <= {GEN_SLOTS{GEN_RST}};
        end else if (acc_wr && acc_hit && acc_port == p[0] && gen_slot(acc_idx) != 3'(GEN_SLOTS)) begin
          gen_reg[p][gen_slot(acc_idx)] <= acc_wdata;
        end
      end
    end
  end

  // Event flags clear on read; a new event wins over the clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_reg <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (rst_busy[p]) begin
          flags_reg[p] <= event_set[p];
        end else if (acc_rd && acc_hit && acc_port == p[0] && acc_idx == IDX_FLAGS) begin
          flags_reg[p] <= event_set[p];
        end else begin
          flags_reg[p] <= flags_reg[p] | event_set[p];
        end
      end
    end
  end

  // Port controls from the control register
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      port_speed_100[p] = ctrl_reg[p][B_AN] ? neg_speed_100[p] : ctrl_reg[p][B_SPD];
      port_full_duplex[p] = ctrl_reg[p][B_AN] ? neg_full_duplex[p] : ctrl_reg[p][B_DUP];
      fabric_loop_enable[p] = ctrl_reg[p][B_LOOP];
      transceiver_power_down[p] = ctrl_reg[p][B_PD];
      negotiation_enable[p] = ctrl_reg[p][B_AN] & ~ctrl_reg[p][B_PD];
      collision_test[p] = ctrl_reg[p][B_COL];
      transceiver_reset_hold[p] = rst_busy[p];
    end
  end

  assign negotiation_restart = restart_reg;
endmodule

// *** pcr_port_regs_monitor.sv ***
// Concurrent checks on the copper port register set.
// Bound into pcr_port_regs; sees its ports only.
module pcr_port_regs_monitor #(
  parameter int unsigned RST_HOLD = 20
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ext_mgmt_mode,
  input wire logic [1:0] strap_autoneg,
  input wire logic [1:0] strap_speed,
  input wire logic ind_cmd_wr,
  input wire logic ind_cmd_read,
  input wire logic [15:0] ind_val_rdata,
  input wire logic mdio_oe,
  input wire logic [1:0] neg_speed_100,
  input wire logic [1:0] neg_full_duplex,
  input wire logic [1:0] port_speed_100,
  input wire logic [1:0] port_full_duplex,
  input wire logic [1:0] fabric_loop_enable,
  input wire logic [1:0] transceiver_power_down,
  input wire logic [1:0] negotiation_enable,
  input wire logic [1:0] transceiver_reset_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold_cnt;
  // Cycles of soft reset hold on port 1
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= transceiver_reset_hold[0] ? hold_cnt + 1 : 0;
    end
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_an_speed_follow: assert property (
    negotiation_enable[1] |-> port_speed_100[1] == neg_speed_100[1]) else $error("speed not from negotiation");
  a_an_duplex_follow: assert property (
    negotiation_enable[1] |-> port_full_duplex[1] == neg_full_duplex[1]) else $error("duplex not from negotiation");
  a_first_strap_load: assert property (
    !$past(nrst) |=> negotiation_enable == strap_autoneg && (strap_autoneg[0] || port_speed_100[0] == strap_speed[0]))
    else $error("strap defaults not loaded");
  a_hold_an_default: assert property (
    transceiver_reset_hold[0] && $past(transceiver_reset_hold[0]) |-> negotiation_enable[0] == strap_autoneg[0])
    else $error("negotiation default lost in soft reset");
  a_hold_loop_clear: assert property (
    transceiver_reset_hold[0] && $past(transceiver_reset_hold[0]) |-> !fabric_loop_enable[0] && !transceiver_power_down[0])
    else $error("control not defaulted in soft reset");
  a_hold_length: assert property (
    $fell(transceiver_reset_hold[0]) |-> hold_cnt >= RST_HOLD && hold_cnt <= RST_HOLD + 1)
    else $error("soft reset hold length wrong");
  a_ind_refused: assert property (
    ext_mgmt_mode && ind_cmd_wr && ind_cmd_read |=> $stable(ind_val_rdata)) else $error("indirect read taken in ext mode");
  a_mdio_quiet: assert property (
    !ext_mgmt_mode && !$past(ext_mgmt_mode) |-> !mdio_oe) else $error("data pin driven in indirect mode");
  c_soft_reset_done: cover property ($fell(transceiver_reset_hold[0]));
  c_mdio_drive: cover property ($rose(mdio_oe));
  c_loop_on: cover property ($rose(fabric_loop_enable[0]));
endmodule

bind pcr_port_regs pcr_port_regs_monitor #(.RST_HOLD(RST_HOLD)) u_mon (
  .clk_sys(clk_sys), .nrst(nrst), .ext_mgmt_mode(ext_mgmt_mode), .strap_autoneg(strap_autoneg),
  .strap_speed(strap_speed), .ind_cmd_wr(ind_cmd_wr), .ind_cmd_read(ind_cmd_read), .ind_val_rdata(ind_val_rdata),
  .mdio_oe(mdio_oe), .neg_speed_100(neg_speed_100), .neg_full_duplex(neg_full_duplex),
  .port_speed_100(port_speed_100), .port_full_duplex(port_full_duplex), .fabric_loop_enable(fabric_loop_enable),
  .transceiver_power_down(transceiver_power_down), .negotiation_enable(negotiation_enable),
  .transceiver_reset_hold(transceiver_reset_hold)
);

// *** pcr_mdio_mgr.sv ***
// Management frame master standing in for the external MAC.
// Assumes the bench resolves the data line with a pull-up.
module pcr_mdio_mgr
  import pcr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic mdio_line,
  output logic mdc,
  output logic mdo,
  output logic mdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mdc = 1'h0;
    mdo = 1'h1;
    mdo_oe = 1'h0;
  end
  // One bit: set while clock low, sample just before the rise
  task automatic bit_slot(input logic drv, input logic v, output logic smp);
    @(negedge clk_sys);
    mdc = 1'h0;
    mdo = v;
    mdo_oe = drv;
    repeat (4) @(negedge clk_sys);
    smp = mdio_line;
    mdc = 1'h1;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] idx, input logic [15:0] wd,
                       output logic [15:0] rv);
    logic [63:0] f;
    logic s;
    f = {32'hffff_ffff, 2'h1, rd ? OP_RD : OP_WR, phy, idx, 2'h2, wd};
    rv = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      bit_slot(!(rd && i < 18), f[i], s);
      if (i < 16) rv[i] = s;
    end
    @(negedge clk_sys);
    mdc = 1'h0;
    mdo_oe = 1'h0;
  endtask
endmodule

// *** pcr_port_regs_bench.sv ***
// Self-checking bench for the copper port register set.
// Uses the frame master model and the bound checker.
module pcr_port_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pcr_pkg::*;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic ext_mgmt_mode = 1'h0;
  logic [1:0] strap_autoneg = 2'h2;
  logic [1:0] strap_speed = 2'h1;
  logic [1:0] strap_duplex = 2'h1;
  logic loader_wr = 1'h0;
  logic loader_port = 1'h0;
  logic [15:0] loader_data = 16'h0000;
  logic ind_cmd_wr = 1'h0;
  logic ind_cmd_read = 1'h0;
  logic [4:0] ind_cmd_addr = 5'h00;
  logic [4:0] ind_cmd_index = 5'h00;
  logic ind_val_wr = 1'h0;
  logic [15:0] ind_val_wdata = 16'h0000;
  logic [15:0] ind_val_rdata;
  logic mdc, mdo, mdo_oe, mdio_o, mdio_oe, mdio_line;
  logic [1:0] neg_done = 2'h3;
  logic [1:0] neg_speed_100 = 2'h0;
  logic [1:0] neg_full_duplex = 2'h2;
  logic [1:0] link_up = 2'h3;
  logic [1:0][15:0] partner_offer = '0;
  logic [1:0][15:0] event_set = '0;
  logic [1:0] restart_seen = 2'h0;
  logic [1:0] port_speed_100, port_full_duplex, fabric_loop_enable, transceiver_power_down;
  logic [1:0] negotiation_enable, negotiation_restart, collision_test, transceiver_reset_hold;
  logic [15:0] exp_q[$];
  logic [15:0] obs;
  logic rd_seen = 1'h0;
  int err_total = 0;
  int comparisons = 0;
  event obs_ev;
  logic [4:0] rw_idx[6] = '{IDX_OFFER, IDX_MODE, IDX_SPECIAL, IDX_INDIC, IDX_ENABLES, IDX_SCTRL};
  logic [4:0] ro_idx[4] = '{IDX_IDH, IDX_IDL, IDX_EXPAN, IDX_FLAGS};

  always #10 clk_sys = ~clk_sys;
  assign mdio_line = mdio_oe ? mdio_o : (mdo_oe ? mdo : 1'h1);

  pcr_port_regs #(.RST_HOLD(20)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .ext_mgmt_mode(ext_mgmt_mode), .strap_autoneg(strap_autoneg),
    .strap_speed(strap_speed), .strap_duplex(strap_duplex), .loader_wr(loader_wr), .loader_port(loader_port),
    .loader_data(loader_data), .ind_cmd_wr(ind_cmd_wr), .ind_cmd_read(ind_cmd_read), .ind_cmd_addr(ind_cmd_addr),
    .ind_cmd_index(ind_cmd_index), .ind_val_wr(ind_val_wr), .ind_val_wdata(ind_val_wdata),
    .ind_val_rdata(ind_val_rdata), .mdc(mdc), .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .neg_done(neg_done), .neg_speed_100(neg_speed_100), .neg_full_duplex(neg_full_duplex), .link_up(link_up),
    .partner_offer(partner_offer), .event_set(event_set), .port_speed_100(port_speed_100),
    .port_full_duplex(port_full_duplex), .fabric_loop_enable(fabric_loop_enable),
    .transceiver_power_down(transceiver_power_down), .negotiation_enable(negotiation_enable),
    .negotiation_restart(negotiation_restart), .collision_test(collision_test),
    .transceiver_reset_hold(transceiver_reset_hold)
  );

  pcr_mdio_mgr mgr (.clk_sys(clk_sys), .mdio_line(mdio_line), .mdc(mdc), .mdo(mdo), .mdo_oe(mdo_oe));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Indirect read results appear one cycle after the command
  always @(posedge clk_sys) rd_seen <= ind_cmd_wr && ind_cmd_read && !ext_mgmt_mode;
  // Restart pulses are caught and kept
  always @(posedge clk_sys) restart_seen <= restart_seen | negotiation_restart;
  always @(negedge clk_sys) if (rd_seen) check(ind_val_rdata, exp_q.pop_front());
  always @(obs_ev) check(obs, exp_q.pop_front());

  task automatic probe(input logic [15:0] seen, input logic [15:0] want);
    exp_q.push_back(want);
    obs = seen;
    ->obs_ev;
    #1;
  endtask

  // Indirect access; a read outside external management mode notes d as the expected word
  task automatic ind(input logic rd, input logic [4:0] a, input logic [4:0] i, input logic [15:0] d);
    if (rd && !ext_mgmt_mode) exp_q.push_back(d);
    if (!rd) begin
      @(negedge clk_sys);
      ind_val_wr = 1'h1;
      ind_val_wdata = d;
    end
    @(negedge clk_sys);
    ind_val_wr = 1'h0;
    {ind_cmd_wr, ind_cmd_read, ind_cmd_addr, ind_cmd_index} = {1'h1, rd, a, i};
    @(negedge clk_sys);
    ind_cmd_wr = 1'h0;
    @(negedge clk_sys);
  endtask

  task automatic md(input logic rd, input logic [4:0] p, input logic [4:0] i, input logic [15:0] d);
    logic [15:0] v;
    mgr.frame(rd, p, i, d, v);
    if (rd) probe(v, d);
  endtask

  task automatic summarize();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    summarize();
  end

  initial begin
    logic [15:0] r;
    void'($urandom(32'h7f47c5e3));
    repeat (3) @(negedge clk_sys);
    nrst = 1'h1;
    repeat (2) @(negedge clk_sys);
    ind(1'h1, 5'h01, IDX_CTRL, 16'h2100);
    ind(1'h1, 5'h02, IDX_CTRL, 16'h3000);
    ind(1'h1, 5'h01, IDX_STATE, 16'h780d);
    ind(1'h1, 5'h02, IDX_STATE, 16'h782d);
    probe({14'h0, port_speed_100[0], port_full_duplex[0]}, 16'h0003);
    ind(1'h0, 5'h01, IDX_CTRL, 16'h047f);
    ind(1'h1, 5'h01, IDX_CTRL, 16'h0000);
    probe({14'h0, port_speed_100[0], port_full_duplex[0]}, 16'h0000);
    ind(1'h0, 5'h01, IDX_CTRL, 16'h4180);
    probe({14'h0, fabric_loop_enable[0], collision_test[0]}, 16'h0003);
    probe({14'h0, port_speed_100[1], negotiation_enable[1]}, 16'h0001);
    // Negotiation cleared before power down
    ind(1'h0, 5'h02, IDX_CTRL, 16'h2000);
    ind(1'h0, 5'h02, IDX_CTRL, 16'h2800);
    probe({15'h0, transceiver_power_down[1]}, 16'h0001);
    ind(1'h1, 5'h02, IDX_STATE, 16'h7809);
    ind(1'h0, 5'h02, IDX_CTRL, 16'h3200);
    ind(1'h1, 5'h02, IDX_STATE, 16'h782d);
    probe({14'h0, restart_seen}, 16'h0002);
    foreach (rw_idx[k]) begin
      r = 16'($urandom);
      ind(1'h0, 5'h01, rw_idx[k], r);
      ind(1'h1, 5'h01, rw_idx[k], r);
    end
    foreach (ro_idx[k]) ind(1'h1, 5'h01, ro_idx[k], 16'h0000);
    partner_offer[0] = 16'($urandom);
    ind(1'h1, 5'h01, IDX_PARTNER, partner_offer[0]);
    event_set[0] = 16'h0012;
    @(negedge clk_sys);
    event_set[0] = 16'h0000;
    ind(1'h1, 5'h01, IDX_FLAGS, 16'h0012);
    ind(1'h1, 5'h01, IDX_FLAGS, 16'h0000);
    ind(1'h1, 5'h02, IDX_ENABLES, 16'h0000);
    ind(1'h1, 5'h03, IDX_CTRL, 16'hffff);
    ind(1'h0, 5'h01, IDX_CTRL, 16'h8000);
    ind(1'h1, 5'h01, IDX_CTRL, 16'ha100);
    for (int n = 0; n < 100 && transceiver_reset_hold[0] !== 1'h0; n++) @(negedge clk_sys);
    ind(1'h1, 5'h01, IDX_CTRL, 16'h2100);
    ind(1'h1, 5'h01, IDX_ENABLES, 16'h0000);
    {loader_wr, loader_port, loader_data} = {1'h1, 1'h1, 16'h0100};
    @(negedge clk_sys);
    loader_wr = 1'h0;
    ind(1'h1, 5'h02, IDX_CTRL, 16'h0100);
    probe({15'h0, port_full_duplex[1]}, 16'h0001);
    ext_mgmt_mode = 1'h1;
    ind(1'h1, 5'h01, IDX_CTRL, 16'h0000);
    r = 16'($urandom);
    md(1'h0, 5'h02, IDX_ENABLES, r);
    md(1'h1, 5'h02, IDX_ENABLES, r);
    md(1'h1, 5'h01, IDX_CTRL, 16'h2100);
    md(1'h1, 5'h03, IDX_CTRL, 16'hffff);
    summarize();
  end
endmodule
